// ---- hdl/tbd_defs.vh ----
// Constants for the 11-bit texture block decoder
`ifndef TBD_DEFS_VH
`define TBD_DEFS_VH
`define TBD_BASE_MSB 63
`define TBD_BASE_LSB 56
`define TBD_MULT_MSB 55
`define TBD_MULT_LSB 52
`define TBD_TAB_MSB 51
`define TBD_TAB_LSB 48
`define TBD_IDX_TOP 47
`define TBD_ROUND_BITS 3'b100
`define TBD_MAX11 11'h7ff
`define TBD_MAX8 8'hff
`define TBD_FMT_SINGLE 2'h0
`define TBD_FMT_DUAL 2'h1
`define TBD_FMT_ALPHA8 2'h2
`define TBD_LATENCY 2
`endif

// ---- hdl/tbd_texture_block_decoder.v ----
// Pipelined decoder for 11-bit single/dual channel and 8-bit alpha texel blocks
`timescale 1ns/1ps
`include "tbd_defs.vh"

// How it works
// - A single-channel block is one 64-bit word holding red for a 4x4 texel block.
// - Bits 63..56 are the unsigned base, multiplied by eight via a left shift by three.
// - Plus four comes from putting 100 into the three vacated low bits, no adder.
// - Bits 51..48 choose one of sixteen eight-entry modifier tables.
// - Each texel has a 3-bit index from bits 47..0, most significant bit first.
// - The index counts table entries from zero at the left.
// - Bits 55..52 are the multiplier; nonzero gives modifier times multiplier shifted left three.
// - Sum base term and modifier term, clamp to 0..2047 for the 11-bit output.
// - A zero multiplier in 11-bit mode adds the unscaled modifier.
// - The 16-bit output is x shifted left five plus x shifted right six.
// - Any other wider result also uses bit replication.
// - Outside alpha mode the result never carries less than 11 bits of precision.
// - Alpha mode drops the three low bits of the sum to form eight bits.
// - Alpha mode clamps to 0..255 after truncation, not before.
// - In alpha mode a zero multiplier gives a zero modifier term; requester names the format.
// - Dual-channel: lower eight bytes carry red, upper eight bytes carry green.
// - Both dual-channel words decode exactly like the single-channel 11-bit format.
// - Sixteen constant rows of eight signed modifiers, four negative then four non-negative.
// - Texel 0 uses bits 47..45, texel 1 bits 44..42, down to texel 15 at 2..0.
module tbd_texture_block_decoder (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Request side
  input wire REQ_VALID,
  output reg REQ_READY,
  input wire [1:0] REQ_FORMAT,
  input wire [63:0] REQ_RED_BYTES,
  input wire [63:0] REQ_GREEN_BYTES,
  input wire [3:0] REQ_TEXEL,
  // Result side
  output reg RES_VALID,
  input wire RES_READY,
  output reg [1:0] RES_FORMAT,
  output reg [10:0] RES_RED_11,
  output reg [10:0] RES_GREEN_11,
  output reg [15:0] RES_RED_16,
  output reg [15:0] RES_GREEN_16,
  output reg [7:0] RES_ALPHA_8
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Bytes arrive with the first byte in bits 7:0; it becomes the top byte
  function [63:0] assemble_word;
    input [63:0] bytes;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        assemble_word[63 - 8 * i -: 8] = bytes[8 * i +: 8];
      end
    end
  endfunction

  // Modifier table, entry selected from the left
  function signed [4:0] modifier_entry;
    input [3:0] tab;
    input [2:0] idx;
    reg [39:0] row;
    begin
      case (tab)
        4'h0: row = {-5'sd3, -5'sd6, -5'sd9, -5'sd15, 5'sd2, 5'sd5, 5'sd8, 5'sd14};
        4'h1: row = {-5'sd3, -5'sd7, -5'sd10, -5'sd13, 5'sd2, 5'sd6, 5'sd9, 5'sd12};
        4'h2: row = {-5'sd2, -5'sd5, -5'sd8, -5'sd13, 5'sd1, 5'sd4, 5'sd7, 5'sd12};
        4'h3: row = {-5'sd2, -5'sd4, -5'sd6, -5'sd13, 5'sd1, 5'sd3, 5'sd5, 5'sd12};
        4'h4: row = {-5'sd3, -5'sd6, -5'sd8, -5'sd12, 5'sd2, 5'sd5, 5'sd7, 5'sd11};
        4'h5: row = {-5'sd3, -5'sd7, -5'sd9, -5'sd11, 5'sd2, 5'sd6, 5'sd8, 5'sd10};
        4'h6: row = {-5'sd4, -5'sd7, -5'sd8, -5'sd11, 5'sd3, 5'sd6, 5'sd7, 5'sd10};
        4'h7: row = {-5'sd3, -5'sd5, -5'sd8, -5'sd11, 5'sd2, 5'sd4, 5'sd7, 5'sd10};
        4'h8: row = {-5'sd2, -5'sd6, -5'sd8, -5'sd10, 5'sd1, 5'sd5, 5'sd7, 5'sd9};
        4'h9: row = {-5'sd2, -5'sd5, -5'sd8, -5'sd10, 5'sd1, 5'sd4, 5'sd7, 5'sd9};
        4'ha: row = {-5'sd2, -5'sd4, -5'sd8, -5'sd10, 5'sd1, 5'sd3, 5'sd7, 5'sd9};
        4'hb: row = {-5'sd2, -5'sd5, -5'sd7, -5'sd10, 5'sd1, 5'sd4, 5'sd6, 5'sd9};
        4'hc: row = {-5'sd3, -5'sd4, -5'sd7, -5'sd10, 5'sd2, 5'sd3, 5'sd6, 5'sd9};
        4'hd: row = {-5'sd1, -5'sd2, -5'sd3, -5'sd10, 5'sd0, 5'sd1, 5'sd2, 5'sd9};
        4'he: row = {-5'sd4, -5'sd6, -5'sd8, -5'sd9, 5'sd3, 5'sd5, 5'sd7, 5'sd8};
        default: row = {-5'sd3, -5'sd5, -5'sd7, -5'sd9, 5'sd2, 5'sd4, 5'sd6, 5'sd8};
      endcase
      modifier_entry = row[39 - 5 * idx -: 5];
    end
  endfunction

  // Decode one texel to a signed 14-bit sum before clamping
  function signed [13:0] texel_sum;
    input [63:0] word;
    input [3:0] texel;
    input alpha8;
    reg [3:0] mult;
    reg [2:0] idx;
    reg signed [4:0] modv;
    reg signed [13:0] base_term;
    reg signed [13:0] mod_term;
    begin
      mult = word[`TBD_MULT_MSB:`TBD_MULT_LSB];
      idx = word[`TBD_IDX_TOP - 3 * texel -: 3];
      modv = modifier_entry(word[`TBD_TAB_MSB:`TBD_TAB_LSB], idx);
      base_term = {3'h0, word[`TBD_BASE_MSB:`TBD_BASE_LSB], `TBD_ROUND_BITS};
      if (mult != 4'h0) begin
        mod_term = ({{9{modv[4]}}, modv} * $signed({10'h0, mult})) <<< 3;
      end else if (alpha8) begin
        mod_term = 14'sh0;
      end else begin
        mod_term = {{9{modv[4]}}, modv};
      end
      texel_sum = base_term + mod_term;
    end
  endfunction

  // Clamp to 0..2047
  function [10:0] clamp_to_eleven_bit_range;
    input signed [13:0] s;
    begin
      if (s[13]) begin
        clamp_to_eleven_bit_range = 11'h000;
      end else if (s > 14'sd2047) begin
        clamp_to_eleven_bit_range = `TBD_MAX11;
      end else begin
        clamp_to_eleven_bit_range = s[10:0];
      end
    end
  endfunction

  // Truncate three low bits then clamp to 0..255
  function [7:0] alpha_value;
    input signed [13:0] s;
    reg signed [13:0] t;
    begin
      t = s >>> 3;
      if (t[13]) begin
        alpha_value = 8'h00;
      end else if (t > 14'sd255) begin
        alpha_value = `TBD_MAX8;
      end else begin
        alpha_value = t[7:0];
      end
    end
  endfunction

  // Bit replication to 16 bits
  function [15:0] widen16;
    input [10:0] x;
    begin
      widen16 = {x, 5'h00} + {11'h000, x[10:6]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1: register the decoded sums

  reg s1_valid_ff;
  reg [1:0] s1_fmt_ff;
  reg signed [13:0] s1_red_ff;
  reg signed [13:0] s1_green_ff;
  wire req_take;
  wire req_alpha;

  assign req_take = REQ_VALID && REQ_READY;
  assign req_alpha = (REQ_FORMAT == `TBD_FMT_ALPHA8);

  // Stage 1 never stalls; the buffer behind it absorbs a held-up receiver
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s1_valid_ff <= 1'b0;
      s1_fmt_ff <= 2'h0;
      s1_red_ff <= 14'sh0;
      s1_green_ff <= 14'sh0;
    end else begin
      s1_valid_ff <= req_take;
      if (req_take) begin
        s1_fmt_ff <= REQ_FORMAT;
        s1_red_ff <= texel_sum(assemble_word(REQ_RED_BYTES), REQ_TEXEL, req_alpha);
        s1_green_ff <= texel_sum(assemble_word(REQ_GREEN_BYTES), REQ_TEXEL, 1'b0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between stage 1 and the output register

  reg [1:0] buf_fmt_ff [0:1];
  reg signed [13:0] buf_red_ff [0:1];
  reg signed [13:0] buf_green_ff [0:1];
  reg [1:0] cnt_ff;
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] nxt_cnt;
  reg nxt_wr_ptr;
  reg nxt_rd_ptr;
  reg [2:0] nxt_in_flight;
  reg nxt_req_ready;
  wire buf_empty;
  wire out_load;
  wire buf_pop;
  wire s1_bypass;
  wire buf_push;

  // The output register takes a word while it is empty or being emptied
  assign buf_empty = (cnt_ff == 2'h0);
  assign out_load = !RES_VALID || RES_READY;
  assign buf_pop = !buf_empty && out_load;
  // An empty buffer lets stage 1 pass straight on, so order is kept
  assign s1_bypass = s1_valid_ff && buf_empty && out_load;
  assign buf_push = s1_valid_ff && !s1_bypass;

  // Ready is registered, so it stays high only while the buffer could
  // still absorb every word in flight if the receiver stalled from now on
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    if (buf_push) begin
      nxt_wr_ptr = ~wr_ptr_ff;
    end
    if (buf_pop) begin
      nxt_rd_ptr = ~rd_ptr_ff;
    end
    if (buf_push && !buf_pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (buf_pop && !buf_push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
    nxt_in_flight = {1'b0, nxt_cnt} + {2'h0, req_take};
    nxt_req_ready = (nxt_in_flight <= 3'h1);
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnt_ff <= 2'h0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      REQ_READY <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      REQ_READY <= nxt_req_ready;
    end
  end

  // Buffer words
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      buf_fmt_ff[0] <= 2'h0;
      buf_fmt_ff[1] <= 2'h0;
      buf_red_ff[0] <= 14'sh0;
      buf_red_ff[1] <= 14'sh0;
      buf_green_ff[0] <= 14'sh0;
      buf_green_ff[1] <= 14'sh0;
    end else if (buf_push) begin
      buf_fmt_ff[wr_ptr_ff] <= s1_fmt_ff;
      buf_red_ff[wr_ptr_ff] <= s1_red_ff;
      buf_green_ff[wr_ptr_ff] <= s1_green_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: pick the source, clamp and widen

  reg [1:0] out_fmt;
  reg signed [13:0] out_red;
  reg signed [13:0] out_green;
  wire out_take;
  wire [10:0] out_red_11;
  wire [10:0] out_green_11;

  assign out_take = buf_pop || s1_bypass;

  // The oldest word is the buffer head when there is one, else stage 1
  always @* begin
    if (!buf_empty) begin
      out_fmt = buf_fmt_ff[rd_ptr_ff];
      out_red = buf_red_ff[rd_ptr_ff];
      out_green = buf_green_ff[rd_ptr_ff];
    end else begin
      out_fmt = s1_fmt_ff;
      out_red = s1_red_ff;
      out_green = s1_green_ff;
    end
  end

  assign out_red_11 = clamp_to_eleven_bit_range(out_red);
  assign out_green_11 = clamp_to_eleven_bit_range(out_green);

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RES_VALID <= 1'b0;
      RES_FORMAT <= 2'h0;
      RES_RED_11 <= 11'h000;
      RES_GREEN_11 <= 11'h000;
      RES_RED_16 <= 16'h0000;
      RES_GREEN_16 <= 16'h0000;
      RES_ALPHA_8 <= 8'h00;
    end else if (out_load) begin
      RES_VALID <= out_take;
      if (out_take) begin
        RES_FORMAT <= out_fmt;
        RES_RED_11 <= out_red_11;
        RES_GREEN_11 <= out_green_11;
        RES_RED_16 <= widen16(out_red_11);
        RES_GREEN_16 <= widen16(out_green_11);
        RES_ALPHA_8 <= alpha_value(out_red);
      end
    end
  end

endmodule

// ---- verification/tbd_decoder_props.sv ----
// Port checks for the texel block decoder
`timescale 1ns/1ps
module tbd_decoder_props (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Handshakes
  input wire REQ_VALID,
  input wire REQ_READY,
  input wire RES_VALID,
  input wire RES_READY,
  // Results
  input wire [1:0] RES_FORMAT,
  input wire [10:0] RES_RED_11,
  input wire [10:0] RES_GREEN_11,
  input wire [15:0] RES_RED_16,
  input wire [15:0] RES_GREEN_16,
  input wire [7:0] RES_ALPHA_8
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_taken; REQ_VALID && REQ_READY; endsequence
  sequence s_stall; RES_VALID && !RES_READY; endsequence
  a_two_cycle_result: assert property (s_taken ##0 !RES_VALID |-> ##2 RES_VALID) else $error("late result");
  a_no_phantom: assert property ($rose(RES_VALID) |-> $past(REQ_VALID && REQ_READY, 2)) else $error("phantom");
  a_valid_held: assert property (s_stall |=> RES_VALID) else $error("result dropped");
  a_data_held: assert property (s_stall |=> $stable({RES_FORMAT, RES_RED_11, RES_GREEN_11, RES_ALPHA_8}))
    else $error("result changed in stall");
  a_ready_when_empty: assert property (!RES_VALID |-> REQ_READY) else $error("refused while empty");
  a_red_widen: assert property (RES_VALID |-> RES_RED_16 == {RES_RED_11, RES_RED_11[10:6]})
    else $error("red widening");
  a_green_widen: assert property (RES_VALID |-> RES_GREEN_16 == {RES_GREEN_11, RES_GREEN_11[10:6]})
    else $error("green widening");
  a_alpha_trunc: assert property (RES_VALID && RES_FORMAT == 2'h2 |-> RES_ALPHA_8 == RES_RED_11[10:3])
    else $error("alpha truncation");
endmodule
bind tbd_texture_block_decoder tbd_decoder_props tbd_decoder_props_inst (.CLK(CLK), .RESET(RESET),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RES_VALID(RES_VALID), .RES_READY(RES_READY),
  .RES_FORMAT(RES_FORMAT), .RES_RED_11(RES_RED_11), .RES_GREEN_11(RES_GREEN_11), .RES_RED_16(RES_RED_16),
  .RES_GREEN_16(RES_GREEN_16), .RES_ALPHA_8(RES_ALPHA_8));

// ---- verification/tbd_sink_model.sv ----
// Filtering stage model that takes results, stalling when asked
`timescale 1ns/1ps
module tbd_sink_model (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Handshake
  input wire slow,
  output reg ready
);
  reg [3:0] cnt_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      ready <= 1'h0;
    end else begin
      cnt_ff <= #1 cnt_ff + 4'h1;
      ready <= #1 !slow || cnt_ff == 4'hf;
    end
  end
endmodule

// ---- verification/test_texture_block_decoder_11bit.sv ----
// Self-checking bench for the texel block decoder
`timescale 1ns/1ps
module test_texture_block_decoder_11bit;
  typedef struct packed {logic [10:0] r; logic [10:0] g; logic [7:0] a; logic [1:0] f;} tbd_exp_t;
  int tab[128] = '{-3,-6,-9,-15,2,5,8,14,-3,-7,-10,-13,2,6,9,12,-2,-5,-8,-13,1,4,7,12,-2,-4,-6,-13,1,3,5,12,
    -3,-6,-8,-12,2,5,7,11,-3,-7,-9,-11,2,6,8,10,-4,-7,-8,-11,3,6,7,10,-3,-5,-8,-11,2,4,7,10,-2,-6,-8,-10,1,5,7,9,
    -2,-5,-8,-10,1,4,7,9,-2,-4,-8,-10,1,3,7,9,-2,-5,-7,-10,1,4,6,9,-3,-4,-7,-10,2,3,6,9,-1,-2,-3,-10,0,1,2,9,
    -4,-6,-8,-9,3,5,7,8,-3,-5,-7,-9,2,4,6,8};
  logic CLK = 1'b0, RESET = 1'b1, REQ_VALID = 1'b0, SLOW = 1'b0;
  logic [1:0] REQ_FORMAT = 0;
  logic [63:0] REQ_RED_BYTES = 0, REQ_GREEN_BYTES = 0;
  logic [3:0] REQ_TEXEL = 0;
  wire REQ_READY, RES_VALID, RES_READY;
  wire [1:0] RES_FORMAT;
  wire [10:0] RES_RED_11, RES_GREEN_11;
  wire [15:0] RES_RED_16, RES_GREEN_16;
  wire [7:0] RES_ALPHA_8;
  tbd_exp_t expq[$];
  tbd_exp_t e;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  tbd_texture_block_decoder tbd_texture_block_decoder_inst (.CLK(CLK), .RESET(RESET), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_FORMAT(REQ_FORMAT), .REQ_RED_BYTES(REQ_RED_BYTES), .REQ_GREEN_BYTES(REQ_GREEN_BYTES),
    .REQ_TEXEL(REQ_TEXEL), .RES_VALID(RES_VALID), .RES_READY(RES_READY), .RES_FORMAT(RES_FORMAT),
    .RES_RED_11(RES_RED_11), .RES_GREEN_11(RES_GREEN_11), .RES_RED_16(RES_RED_16), .RES_GREEN_16(RES_GREEN_16),
    .RES_ALPHA_8(RES_ALPHA_8));
  tbd_sink_model tbd_sink_model_inst (.clk(CLK), .rst(RESET), .slow(SLOW), .ready(RES_READY));
  initial forever #5 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int raw_sum(logic [63:0] w, logic [3:0] t, logic a8);
    int m;
    m = tab[w[51:48] * 8 + w[47 - 3 * t -: 3]];
    if (w[55:52] != 4'h0) m = m * int'(w[55:52]) * 8;
    else if (a8) m = 0;
    return int'(w[63:56]) * 8 + 4 + m;
  endfunction
  function automatic int clip(int s, int hi);
    return s < 0 ? 0 : s > hi ? hi : s;
  endfunction
  function automatic logic [63:0] swap(logic [63:0] w);
    for (int i = 0; i < 8; i++) swap[8 * i +: 8] = w[63 - 8 * i -: 8];
  endfunction
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task send(input logic [63:0] wr, input logic [63:0] wg, input logic [1:0] f, input logic [3:0] t);
    logic tk;
    expq.push_back('{11'(clip(raw_sum(wr, t, f == 2'h2), 2047)), 11'(clip(raw_sum(wg, t, 1'b0), 2047)),
      8'(clip(raw_sum(wr, t, f == 2'h2) >>> 3, 255)), f});
    REQ_VALID = 1'h1;
    REQ_FORMAT = f;
    REQ_RED_BYTES = swap(wr);
    REQ_GREEN_BYTES = swap(wg);
    REQ_TEXEL = t;
    do begin
      @(negedge CLK);
      tk = REQ_READY;
      @(posedge CLK);
    end while (tk !== 1'h1);
    #1;
  endtask
  task drain;
    int k;
    k = 0;
    REQ_VALID = 1'h0;
    while (expq.size() > 0 && k < 300) begin
      @(posedge CLK);
      #1;
      k++;
    end
    cmp(16'(expq.size()), 16'h0);
  endtask
  task t_example;
    send({8'h67, 4'h2, 4'hd, 48'h0c0000000000}, 64'h0, 2'h0, 4'h1);
    send({8'h67, 4'h0, 4'hd, 48'h0c0000000000}, 64'h0, 2'h0, 4'h1);
    drain;
  endtask
  task t_sweep(input logic slow);
    SLOW = slow;
    for (int i = 0; i < 256; i++)
      send({{4{i[7:4]}}, 48'h053977053977}, ~{{4{i[7:4]}}, 48'h053977053977}, 2'(i % 3), i[3:0]);
    drain;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end else if (RES_VALID === 1'h1 && RES_READY === 1'h1) begin
      e = expq.pop_front();
      cmp(16'(RES_FORMAT), 16'(e.f));
      cmp(16'(RES_RED_11), 16'(e.r));
      cmp(RES_RED_16, {e.r, e.r[10:6]});
      if (e.f == 2'h2) cmp(16'(RES_ALPHA_8), 16'(e.a));
      if (e.f == 2'h1) cmp(16'(RES_GREEN_11), 16'(e.g));
      if (e.f == 2'h1) cmp(RES_GREEN_16, {e.g, e.g[10:6]});
    end
  end
  initial begin
    repeat (10) @(posedge CLK);
    cmp(16'(REQ_READY), 16'h1);
    #1 RESET = 1'h0;
    t_example;
    t_sweep(1'h0);
    t_sweep(1'h1);
    tally_and_finish;
  end
endmodule
